/* File: rtl/sac_pkg.sv */
// package of the serial converter control block: control byte layout,
// converter states, reset values and timing counts.
// assumes a 125 MHz system clock; all users write sac_pkg::name.
package sac_pkg;

  // system clock rate
  localparam int unsigned MCLK_HZ = 125_000_000;

  // power-on reset time in microseconds, rounded up to whole cycles
  localparam int unsigned POR_US     = 10;
  localparam int unsigned POR_CYCLES = (POR_US * MCLK_HZ + 999_999) / 1_000_000;
  localparam int          POR_W      = 11;

  // internal conversion clock rates, divider rounded down
  localparam int unsigned INT_FAST_HZ = 1_800_000;
  localparam int unsigned INT_SLOW_HZ = 225_000;
  localparam int unsigned DIV_FAST    = MCLK_HZ / INT_FAST_HZ;
  localparam int unsigned DIV_SLOW    = MCLK_HZ / INT_SLOW_HZ;
  localparam int          DIV_W       = 10;

  // result and control byte sizes
  localparam int          RES_W       = 12;
  localparam logic [3:0]  MSB_STEP    = 4'hB;
  localparam logic [3:0]  OVERLAP_STEP = 4'h5;
  localparam logic [3:0]  LAST_RX_CNT = 4'h7;
  localparam logic [3:0]  ACQ_RX_CNT  = 4'h5;

  // control byte field positions within the seven bits after the start bit
  localparam int          SEL_HI      = 6;
  localparam int          SEL_LO      = 4;
  localparam int          UNI_POS     = 3;
  localparam int          SGL_POS     = 2;
  localparam int          MODE_HI     = 1;

  // mode bit pair encodings
  localparam logic [1:0]  MODE_FULL_PD = 2'h0;
  localparam logic [1:0]  MODE_FAST_PD = 2'h1;
  localparam logic [1:0]  MODE_INT_CLK = 2'h2;
  localparam logic [1:0]  MODE_EXT_CLK = 2'h3;

  // converter states, gray along idle, strobe, external, internal
  typedef enum logic [1:0] {
    CNV_IDLE = 2'h0,
    CNV_STRB = 2'h1,
    CNV_EXT  = 2'h3,
    CNV_INT  = 2'h2
  } sac_cnv_type;

  // decoded control byte
  typedef struct packed {
    logic [2:0] channel_sel;
    logic       polarity_select;
    logic       input_config_select;
    logic [1:0] mode;
  } sac_ctrl_type;

  // whole state of the control block
  typedef struct packed {
    logic              sclk_q;
    logic              cs_n_q;
    logic [POR_W-1:0]  por_cnt;
    sac_cnv_type       cnv;
    logic [3:0]        rx_cnt;
    logic [6:0]        rx_sh;
    logic              pend;
    sac_ctrl_type      ctrl;
    logic              clk_ext;
    logic              cs_tog;
    logic [3:0]        step;
    logic [RES_W-1:0]  code;
    logic [RES_W-1:0]  trial;
    logic [RES_W-1:0]  out_sh;
    logic [DIV_W-1:0]  div_cnt;
    logic              pwr_on;
    logic              pd_after;
    logic              acquire;
    logic              powered;
    logic              fast_pd;
    logic              full_pd;
    logic              dout;
    logic              dout_oe_n;
    logic              strobe;
    logic              strobe_oe_n;
    logic              strb_ext;
  } sac_state_type;

  localparam logic [RES_W-1:0] RES_ZERO = 12'h000;
  localparam logic [RES_W-1:0] RES_ONE  = 12'h001;

endpackage : sac_pkg

/* File: rtl/sac_sync.sv */
// two flip-flop synchroniser for a group of levels from outside the clock.
// assumes an active-low asynchronous reset already released in step.
`timescale 1ns/1ps
module sac_sync #(
  parameter int W = 5
) (
  // clock and reset
  input  wire logic         i_clk,
  input  wire logic         i_rst_n,
  // raw levels and synchronised copy
  input  wire logic [W-1:0] i_d,
  output logic      [W-1:0] o_q
);

  logic [W-1:0] meta_reg;

  // first stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_reg <= '0;
      o_q      <= '0;
    end else begin
      meta_reg <= i_d;
      o_q      <= meta_reg;
    end
  end

endmodule : sac_sync

/* File: rtl/sac_ctrl.sv */
// control logic of an 8-channel 12-bit serial converter: framing,
// conversion sequencing, strobe, result shifting and power-down.
// assumes the serial pins and shutdown pin arrive asynchronously and the
// analog comparator answers the trial code within one system clock.
`timescale 1ns/1ps
module sac_ctrl (
  // clock and reset
  input  wire logic              i_mclk,
  input  wire logic              i_resetn,
  // serial port pins
  input  wire logic              i_cs_n,
  input  wire logic              i_sclk,
  input  wire logic              i_din,
  output logic                   o_dout,
  output logic                   o_dout_oe_n,
  output logic                   o_conversion_strobe,
  output logic                   o_conversion_strobe_oe_n,
  // shutdown pin, low forces power-down; float flag marks it undriven
  input  wire logic              i_hard_shutdown_pin,
  input  wire logic              i_hard_shutdown_pin_float,
  // analog side
  input  wire logic              i_cmp_high,
  output logic [2:0]             o_channel_sel,
  output logic                   o_polarity_select,
  output logic                   o_input_config_select,
  output logic [11:0]            o_sar_trial,
  output logic                   o_acquire,
  // power status
  output logic                   o_powered,
  output logic                   o_fast_power_down,
  output logic                   o_full_power_down
);

  // reset release and synchronised pins
  logic [1:0]             rst_ff;
  logic                   rst_n;
  logic [4:0]             pin_q;
  logic                   sclk;
  logic                   cs_n;
  logic                   din;
  logic                   hard_shutdown_pin_n;
  logic                   hard_shutdown_pin_float;

  sac_pkg::sac_state_type st_reg;
  sac_pkg::sac_state_type st_next;

  // result coding: bipolar inverts the msb of the offset code
  function automatic logic [11:0] out_code(input logic [11:0] c,
                                           input logic        uni);
    out_code = {c[11] ^ ~uni, c[10:0]};
  endfunction : out_code

  // reset released through two flip-flops
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      rst_ff <= 2'h0;
    end else begin
      rst_ff <= {rst_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_ff[1];

  sac_sync #(.W(5)) u_sync (
    .i_clk  (i_mclk),
    .i_rst_n(rst_n),
    .i_d    ({i_sclk, ~i_cs_n, i_din, ~i_hard_shutdown_pin,
              i_hard_shutdown_pin_float}),
    .o_q    (pin_q)
  );
  // select and shutdown pass inverted so cleared flops read as idle pins
  assign {sclk, cs_n, din, hard_shutdown_pin_n, hard_shutdown_pin_float} =
    {pin_q[4], ~pin_q[3], pin_q[2], ~pin_q[1], pin_q[0]};

  // internal clock divider reload values
  localparam logic [sac_pkg::DIV_W-1:0] DIV_W_FAST =
    sac_pkg::DIV_W'(sac_pkg::DIV_FAST - 1);
  localparam logic [sac_pkg::DIV_W-1:0] DIV_W_SLOW =
    sac_pkg::DIV_W'(sac_pkg::DIV_SLOW - 1);

  // next state of the whole block
  always_comb begin
    logic                 rise;
    logic                 fall;
    logic                 cs_fall;
    logic                 cs_rise;
    logic                 busy;
    logic                 hunt_ok;
    logic                 ext;
    logic [11:0]          c;
    sac_pkg::sac_ctrl_type cb;
    rise    = 1'b0;
    fall    = 1'b0;
    cs_fall = 1'b0;
    cs_rise = 1'b0;
    busy    = 1'b0;
    hunt_ok = 1'b0;
    ext     = 1'b0;
    c       = sac_pkg::RES_ZERO;
    cb      = '0;
    st_next = st_reg;

    // edge finding on the sampled serial clock and select
    rise    = sclk & ~st_reg.sclk_q;
    fall    = ~sclk & st_reg.sclk_q;
    cs_fall = ~cs_n & st_reg.cs_n_q;
    cs_rise = cs_n & ~st_reg.cs_n_q;
    st_next.sclk_q = sclk;
    st_next.cs_n_q = cs_n;

    // power-on reset time blocks start bits
    if (st_reg.por_cnt != '0) begin
      st_next.por_cnt = st_reg.por_cnt - 1'b1;
    end

    busy    = (st_reg.cnv != sac_pkg::CNV_IDLE);
    hunt_ok = (st_reg.por_cnt == '0) &&
              (!busy || st_reg.cs_tog ||
               (st_reg.cnv == sac_pkg::CNV_EXT &&
                st_reg.step < sac_pkg::OVERLAP_STEP));

    // select falling: drive pins, restart framing, start nothing
    if (cs_fall) begin
      st_next.dout_oe_n   = 1'b0;
      st_next.strobe_oe_n = 1'b0;
      st_next.rx_cnt      = 4'h0;
      st_next.pend        = 1'b0;
      if (st_reg.strb_ext) begin
        st_next.strobe = 1'b0;
      end
      if (busy) begin
        st_next.cs_tog = 1'b1;
      end
    end

    // select rising: float data; external strobe floats, external-clock conversion ends
    if (cs_rise) begin
      st_next.dout_oe_n   = 1'b1;
      st_next.strobe_oe_n = st_reg.strb_ext;
      st_next.rx_cnt      = 4'h0;
      st_next.pend        = 1'b0;
      if (st_reg.cnv == sac_pkg::CNV_STRB ||
          st_reg.cnv == sac_pkg::CNV_EXT) begin
        st_next.cnv = sac_pkg::CNV_IDLE;
      end
    end

    // receiver: hunt the start bit, then collect seven more bits
    if (rise && !cs_n) begin
      if (st_reg.rx_cnt == 4'h0) begin
        if (din && hunt_ok) begin
          st_next.rx_cnt = 4'h1;
        end
      end else begin
        st_next.rx_sh  = {st_reg.rx_sh[5:0], din};
        st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
        if (st_reg.rx_cnt == sac_pkg::LAST_RX_CNT) begin
          st_next.pend   = 1'b1;
          st_next.rx_cnt = 4'h0;
        end
      end
    end

    // falling serial clock: start, external steps or result readout
    if (fall && !cs_n) begin
      if (st_reg.pend) begin
        cb.channel_sel         = st_reg.rx_sh[sac_pkg::SEL_HI:sac_pkg::SEL_LO];
        cb.polarity_select     = st_reg.rx_sh[sac_pkg::UNI_POS];
        cb.input_config_select = st_reg.rx_sh[sac_pkg::SGL_POS];
        cb.mode                = st_reg.rx_sh[sac_pkg::MODE_HI:0];
        // power-down bytes convert once in the previous clock mode
        ext = cb.mode[1] ? (cb.mode == sac_pkg::MODE_EXT_CLK)
                         : st_reg.clk_ext;
        st_next.pend     = 1'b0;
        st_next.ctrl     = cb;
        st_next.clk_ext  = ext;
        st_next.pwr_on   = 1'b1;
        st_next.pd_after = ~cb.mode[1];
        st_next.cs_tog   = 1'b0;
        st_next.code     = sac_pkg::RES_ZERO;
        st_next.step     = sac_pkg::MSB_STEP;
        st_next.strb_ext = ext;
        st_next.dout     = 1'b0;
        if (ext) begin
          st_next.cnv    = sac_pkg::CNV_STRB;
          st_next.strobe = 1'b1;
        end else begin
          st_next.cnv     = sac_pkg::CNV_INT;
          st_next.strobe  = 1'b0;
          st_next.div_cnt = hard_shutdown_pin_float ? DIV_W_FAST : DIV_W_SLOW;
        end
      end else if (st_reg.cnv == sac_pkg::CNV_STRB ||
                   st_reg.cnv == sac_pkg::CNV_EXT) begin
        // one bit decided and driven per falling edge
        c = st_reg.code;
        c[st_reg.step] = i_cmp_high;
        st_next.code   = c;
        st_next.strobe = 1'b0;
        st_next.cnv    = sac_pkg::CNV_EXT;
        st_next.dout   = (st_reg.step == sac_pkg::MSB_STEP)
                         ? i_cmp_high ^ ~st_reg.ctrl.polarity_select
                         : i_cmp_high;
        if (st_reg.step == 4'h0) begin
          st_next.cnv    = sac_pkg::CNV_IDLE;
          st_next.pwr_on = ~st_reg.pd_after;
          st_next.out_sh = sac_pkg::RES_ZERO;
        end else begin
          st_next.step = st_reg.step - 4'h1;
        end
      end else begin
        // stored result, zeros once used or before any conversion
        st_next.dout   = st_reg.out_sh[11];
        st_next.out_sh = {st_reg.out_sh[10:0], 1'b0};
      end
    end

    // internal clock steps run on the divided system clock
    if (st_reg.cnv == sac_pkg::CNV_INT) begin
      if (st_reg.div_cnt == '0) begin
        st_next.div_cnt = hard_shutdown_pin_float ? DIV_W_FAST : DIV_W_SLOW;
        c = st_reg.code;
        c[st_reg.step] = i_cmp_high;
        st_next.code = c;
        if (st_reg.step == 4'h0) begin
          st_next.cnv    = sac_pkg::CNV_IDLE;
          st_next.strobe = 1'b1;
          st_next.out_sh = out_code(c, st_reg.ctrl.polarity_select);
          st_next.pwr_on = ~st_reg.pd_after;
        end else begin
          st_next.step = st_reg.step - 4'h1;
        end
      end else begin
        st_next.div_cnt = st_reg.div_cnt - 1'b1;
      end
    end

    // shutdown pin low: stop at once and hunt again
    if (!hard_shutdown_pin_n) begin
      st_next.cnv    = sac_pkg::CNV_IDLE;
      st_next.rx_cnt = 4'h0;
      st_next.pend   = 1'b0;
      st_next.cs_tog = 1'b0;
      st_next.pwr_on = 1'b0;
    end

    // registered views for the outputs
    st_next.trial = (st_next.cnv != sac_pkg::CNV_IDLE)
                    ? st_next.code | (sac_pkg::RES_ONE << st_next.step)
                    : sac_pkg::RES_ZERO;
    st_next.acquire = (st_next.rx_cnt >= sac_pkg::ACQ_RX_CNT) ||
                      st_next.pend;
    st_next.powered = st_next.pwr_on & hard_shutdown_pin_n;
    st_next.fast_pd = ~st_next.powered & hard_shutdown_pin_n &
                      (st_next.ctrl.mode == sac_pkg::MODE_FAST_PD);
    st_next.full_pd = ~st_next.powered & ~st_next.fast_pd;
  end

  // state register, reset into internal mode with strobe high
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg             <= '0;
      st_reg.cs_n_q      <= 1'b1;
      st_reg.por_cnt     <= sac_pkg::POR_W'(sac_pkg::POR_CYCLES);
      st_reg.cnv         <= sac_pkg::CNV_IDLE;
      st_reg.ctrl.mode   <= sac_pkg::MODE_INT_CLK;
      st_reg.pwr_on      <= 1'b1;
      st_reg.powered     <= 1'b1;
      st_reg.dout_oe_n   <= 1'b1;
      st_reg.strobe      <= 1'b1;
      st_reg.strobe_oe_n <= 1'b0;
    end else begin
      st_reg <= st_next;
    end
  end

  // outputs straight from the state register
  assign o_dout                   = st_reg.dout;
  assign o_dout_oe_n              = st_reg.dout_oe_n;
  assign o_conversion_strobe      = st_reg.strobe;
  assign o_conversion_strobe_oe_n = st_reg.strobe_oe_n;
  assign o_channel_sel            = st_reg.ctrl.channel_sel;
  assign o_polarity_select        = st_reg.ctrl.polarity_select;
  assign o_input_config_select    = st_reg.ctrl.input_config_select;
  assign o_sar_trial              = st_reg.trial;
  assign o_acquire                = st_reg.acquire;
  assign o_powered                = st_reg.powered;
  assign o_fast_power_down        = st_reg.fast_pd;
  assign o_full_power_down        = st_reg.full_pd;

endmodule : sac_ctrl

/* File: tb/sac_ctrl_checker.sv */
// checker of the serial converter control: port-level properties.
// bound to sac_ctrl; sees only its ports, one clock domain.
`timescale 1ns/1ps
module sac_ctrl_checker (
  // clock, reset and pins
  input wire logic        i_mclk,
  input wire logic        i_resetn,
  input wire logic        i_cs_n,
  input wire logic        i_sclk,
  input wire logic        i_hard_shutdown_pin,
  // outputs watched
  input wire logic        o_dout,
  input wire logic        o_dout_oe_n,
  input wire logic        o_conversion_strobe_oe_n,
  input wire logic [11:0] o_sar_trial,
  input wire logic        o_acquire,
  input wire logic        o_powered
);
  logic [12:0] busy_reg;
  logic [10:0] por_reg;
  logic        seen_reg;

  // conversion length, time since reset, first conversion seen
  always_ff @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      busy_reg <= 13'h0000;
      por_reg  <= 11'h000;
      seen_reg <= 1'b0;
    end else begin
      busy_reg <= (o_sar_trial != 12'h000) ? busy_reg + 13'h0001 : 13'h0000;
      por_reg  <= (por_reg == 11'h7FF) ? por_reg : por_reg + 11'h001;
      seen_reg <= seen_reg | (o_sar_trial != 12'h000);
    end
  end

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);

  // a conversion begins when the trial code leaves zero
  sequence s_conv_begin;
    $rose(o_sar_trial != 12'h000);
  endsequence
  // select held high long enough to pass the pin synchroniser
  sequence s_sel_high;
    i_cs_n [*8];
  endsequence

  AST_MSB_TRIAL: assert property (
    s_conv_begin |-> o_sar_trial == 12'h800) else $error("first trial bad");
  AST_START_ON_FALL: assert property (
    s_conv_begin |-> !i_sclk) else $error("start not after a fall");
  AST_BUSY_BOUND: assert property (
    busy_reg < 13'h1B58) else $error("conversion too long");
  AST_POR_QUIET: assert property (
    por_reg < 11'h4D8 |-> o_sar_trial == 12'h000) else $error("start in por");
  AST_ZERO_OUT: assert property (
    !seen_reg |-> !o_dout) else $error("data before conversion");
  AST_SEL_FLOAT: assert property (
    s_sel_high |-> o_dout_oe_n) else $error("data driven, select high");
  AST_NO_FRAME: assert property (
    s_sel_high |-> !$rose(o_acquire)) else $error("framing, select high");
  AST_HARD_SHUTDOWN_PIN_OFF: assert property (
    !i_hard_shutdown_pin [*6] |-> !o_powered && o_sar_trial == 12'h000)
    else $error("not off in shutdown");
  AST_STRB_FLOAT: assert property (
    o_conversion_strobe_oe_n |-> o_dout_oe_n) else $error("strobe floats");
endmodule : sac_ctrl_checker

bind sac_ctrl sac_ctrl_checker u_sac_ctrl_checker (
  .i_mclk(i_mclk), .i_resetn(i_resetn), .i_cs_n(i_cs_n), .i_sclk(i_sclk),
  .i_hard_shutdown_pin(i_hard_shutdown_pin), .o_dout(o_dout),
  .o_dout_oe_n(o_dout_oe_n), .o_sar_trial(o_sar_trial),
  .o_conversion_strobe_oe_n(o_conversion_strobe_oe_n),
  .o_acquire(o_acquire), .o_powered(o_powered));

/* File: tb/sac_spi_master.sv */
// serial master model: drives select, serial clock and data in.
// assumes the bench calls its tasks; clock stands low between frames.
`timescale 1ns/1ps
module sac_spi_master (
  // converter outputs
  input  wire logic i_dout,
  input  wire logic i_strobe,
  // pins towards the converter
  output logic      o_cs_n,
  output logic      o_sclk,
  output logic      o_din
);
  realtime half_ns = 62.5;

  // idle pins
  initial begin
    o_cs_n = 1'b1;
    o_sclk = 1'b0;
    o_din  = 1'b0;
  end

  // select level, then let the synchroniser settle
  task automatic sel(input logic v);
    #0.5;
    o_cs_n = v;
    #200;
  endtask : sel

  // n bits msb first; data out and strobe are sampled at each rise
  task automatic xfer(input logic [47:0] tx, input int n,
                      output logic [47:0] rx, output logic [47:0] rs);
    rx = 48'h0;
    rs = 48'h0;
    #0.5;
    for (int i = n - 1; i >= 0; i--) begin
      o_din = tx[i];
      #(half_ns / 2.0);
      o_sclk = 1'b1;
      rx[i] = i_dout;
      rs[i] = i_strobe;
      #(half_ns);
      o_sclk = 1'b0;
      #(half_ns / 2.0);
    end
    o_din = ~o_din; // data no longer valid after its bit
  endtask : xfer
endmodule : sac_spi_master

/* File: tb/sac_ctrl_tb_top.sv */
// self-checking bench of the serial converter control block.
// assumes a comparator model and a serial master model on the pins.
`timescale 1ns/1ps
module sac_ctrl_tb_top;
  typedef struct packed {
    logic [7:0]  ctrl;
    logic        int_conv;
    logic        fl;
    logic [11:0] vin;
    logic [2:0]  pwr;
  } sac_row_type;

  logic        mclk, resetn, cs_n, sclk, din, dout, dout_oe_n, strb;
  logic        strb_oe_n, hsd_pin, hsd_float, cmp, pol, cfg, acq;
  logic        pwr, fpd, ful;
  logic [2:0]  chsel;
  logic [11:0] trial, vin;
  logic [47:0] rx, rs;
  int          bad_count, n_checks;
  sac_row_type rows [0:5];

  sac_ctrl u_sac_ctrl (.i_mclk(mclk), .i_resetn(resetn), .i_cs_n(cs_n),
    .i_sclk(sclk), .i_din(din), .o_dout(dout), .o_dout_oe_n(dout_oe_n),
    .o_conversion_strobe(strb), .o_conversion_strobe_oe_n(strb_oe_n),
    .i_hard_shutdown_pin(hsd_pin), .i_hard_shutdown_pin_float(hsd_float),
    .i_cmp_high(cmp), .o_channel_sel(chsel), .o_polarity_select(pol),
    .o_input_config_select(cfg), .o_sar_trial(trial), .o_acquire(acq),
    .o_powered(pwr), .o_fast_power_down(fpd), .o_full_power_down(ful));
  sac_spi_master u_sac_spi_master (.i_dout(dout), .i_strobe(strb),
    .o_cs_n(cs_n), .o_sclk(sclk), .o_din(din));

  // comparator: input at or above the trial keeps the bit
  assign cmp = (vin >= trial);

  // system clock
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test

  // one framed conversion and its readout
  task automatic run_row(input sac_row_type r);
    logic [11:0] exp;
    int          lo;
    exp = r.ctrl[3] ? r.vin : (r.vin ^ 12'h800); // bipolar is msb flipped
    lo = 0;
    @(posedge mclk);
    hsd_float <= r.fl; // rows after a power-down float the pin
    vin <= r.vin;
    u_sac_spi_master.half_ns = r.int_conv ? 250.0 : 62.5;
    u_sac_spi_master.sel(1'b0);
    chk(16'(strb_oe_n), 16'h0000);
    if (r.int_conv) begin
      u_sac_spi_master.xfer({40'h0, r.ctrl}, 8, rx, rs);
      // serial clock held low until the strobe rises
      while (strb !== 1'b1 && lo < 8000) begin
        @(negedge mclk);
        lo++;
      end
      if (r.fl) chk(16'(lo <= 938), 16'h0001);
      if (!r.fl) chk(16'(lo > 938), 16'h0001);
      u_sac_spi_master.xfer(48'h0, 16, rx, rs);
    end else begin
      u_sac_spi_master.xfer({24'h0, r.ctrl, 16'h0}, 24, rx, rs);
      chk(16'(rs[15:13]), 16'h0004);
    end
    chk(16'(rx[14:3]), 16'(exp));
    chk(16'({chsel, pol, cfg}), 16'(r.ctrl[6:2]));
    u_sac_spi_master.sel(1'b1);
    chk(16'({dout_oe_n, strb_oe_n}), 16'({1'b1, ~r.int_conv}));
    chk(16'({pwr, fpd, ful}), 16'(r.pwr));
  endtask : run_row

  // main sequence
  initial begin
    resetn = 1'b0;
    hsd_pin = 1'b1;
    hsd_float = 1'b1;
    vin = 12'h000;
    bad_count = 0;
    n_checks = 0;
    rows[0] = '{8'hDF, 1'b0, 1'b1, 12'hA5C, 3'h4};
    rows[1] = '{8'hA2, 1'b1, 1'b1, 12'h3C1, 3'h4};
    rows[2] = '{8'hF8, 1'b1, 1'b0, 12'hFFF, 3'h1};
    rows[3] = '{8'h87, 1'b0, 1'b1, 12'h000, 3'h4};
    rows[4] = '{8'hBD, 1'b0, 1'b1, 12'h7FF, 3'h2};
    rows[5] = '{8'hEE, 1'b1, 1'b1, 12'h800, 3'h4};
    repeat (12) @(posedge mclk);
    chk({dout_oe_n, strb, strb_oe_n, pwr, trial}, 16'hD000);
    resetn <= 1'b1;
    repeat (4) @(posedge mclk);
    u_sac_spi_master.sel(1'b0);
    u_sac_spi_master.xfer(48'h0, 16, rx, rs);
    chk(rx[15:0], 16'h0000);
    u_sac_spi_master.xfer({40'h0, 8'hFF}, 8, rx, rs);
    repeat (20) @(posedge mclk);
    chk(16'({strb, strb_oe_n, trial}), 16'h2000);
    u_sac_spi_master.sel(1'b1);
    repeat (1300) @(posedge mclk);
    foreach (rows[i]) run_row(rows[i]);
    // overlapped frames, next start bit right after result bit 5
    @(posedge mclk);
    vin <= 12'h5A3;
    u_sac_spi_master.half_ns = 62.5;
    u_sac_spi_master.sel(1'b0);
    u_sac_spi_master.xfer({9'h0, 8'hDF, 7'h0, 8'hD7, 16'h0}, 39, rx, rs);
    chk(16'(rx[29:18]), 16'h05A3);
    chk(16'(rx[14:3]), 16'h0DA3);
    // select toggled in mid-conversion, leading zeros then a new byte
    u_sac_spi_master.xfer({35'h0, 8'hDF, 5'h0}, 13, rx, rs);
    u_sac_spi_master.sel(1'b1);
    @(posedge mclk);
    vin <= 12'h123;
    u_sac_spi_master.sel(1'b0);
    u_sac_spi_master.xfer({20'h0, 4'h0, 8'hCB, 16'h0}, 28, rx, rs);
    chk(16'(rx[14:3]), 16'h0123);
    u_sac_spi_master.sel(1'b1);
    // shutdown pin pulled low during a slow internal conversion
    @(posedge mclk);
    hsd_float <= 1'b0;
    u_sac_spi_master.half_ns = 250.0;
    u_sac_spi_master.sel(1'b0);
    u_sac_spi_master.xfer({40'h0, 8'hA2}, 8, rx, rs);
    repeat (100) @(posedge mclk);
    chk(16'(trial !== 12'h000), 16'h0001);
    hsd_pin <= 1'b0;
    repeat (10) @(posedge mclk);
    chk(16'({pwr, trial}), 16'h0000);
    hsd_float <= 1'b1;
    hsd_pin <= 1'b1;
    repeat (10) @(posedge mclk);
    u_sac_spi_master.sel(1'b1);
    run_row(rows[0]);
    finish_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    #600_000;
    bad_count++;
    finish_test();
  end
endmodule : sac_ctrl_tb_top
